/* src/snpf_filter.sv */
`timescale 1ns/10ps
`include "snpf_map.svh"
// Operation
// RQ1: Forward snoop addresses on host address lines; filtered snoops free them. Code never frees them: snoopAddr always drives the last snoop address.
// RQ2: Latch system address at end of each system-to-memory write.
// RQ3: Same cache line as latched address means no snoop forwarded.
// RQ4: Different line raises snoop request and runs the acknowledge handshake; code only requests in SNPF_IDLE, misses during a pending snoop get none.
// RQ5: Ownership change of memory or bus invalidates the filter.
// RQ6: Processor-subsystem write during pending snoop holds ready low until acknowledge.
// RQ7: Burst write drops ready for exactly one clock in next write.
// RQ8: Snoop request asserts in first state after memory write appears.
// RQ9: Host keeps request-to-acknowledge delay short, under 180 ns.
// RQ10: Host gives pending invalidation priority over new host cycles.
// RQ11: Host completes snoops at least as fast as writes arrive.
// RQ12: Host asserts address hold in S2, acknowledge in S4.
// RQ13: Host withholds its address strobe when address hold coincides.
// RQ14: Host asserts external address strobe once snoop address meets setup.
// RQ15: Host keeps address hold one extra cycle after strobe negates.
// RQ16: Host keeps address hold while synchronized request stays active.
// RQ17: With no requests left, host releases hold and issues stalled cycle.
// RQ18: Valid flag guards the latch; cleared at reset and ownership change.
// RQ19: Compare ignores bits below line size, matches all upper bits.
module snpf_filter
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // System write side
   input wire snpf_pkg::snpf_write_t sysWrite,
   input wire logic ownershipChange,
   input wire logic [1:0] lineSize,
   // Host snoop handshake
   input wire logic snoopAcknowledge_n,
   output logic snoopRequest,
   output logic [31:0] snoopAddr,
   // Memory ready
   output logic memoryReady
);
   function automatic logic [31:0] lineMask(input logic [1:0] sz);
      case (sz)
         `SNPF_LSZ_16: lineMask = 32'hFFFFFFFF << `SNPF_LINE_LSB_16;
         `SNPF_LSZ_32: lineMask = 32'hFFFFFFFF << `SNPF_LINE_LSB_32;
         `SNPF_LSZ_64: lineMask = 32'hFFFFFFFF << `SNPF_LINE_LSB_64;
         default: lineMask = 32'hFFFFFFFF << `SNPF_LINE_LSB_128;
      endcase
   endfunction

   snpf_pkg::snpf_state_t state_r, state_nxt;
   logic [31:0] latch_r, latch_nxt;
   logic valid_r, valid_nxt;
   logic req_r, req_nxt;
   logic [31:0] sAddr_r, sAddr_nxt;
   logic rdy_r, rdy_nxt;
   logic stall_r, stall_nxt;
   logic burstDip_r, burstDip_nxt;
   logic pending, sameLine;

   assign pending = req_r || !snoopAcknowledge_n;
   assign sameLine = valid_r &&
      (((sysWrite.addr ^ latch_r) & lineMask(lineSize)) == 32'h00000000); // RQ19

   always_comb
   begin
      state_nxt = state_r;
      latch_nxt = latch_r;
      valid_nxt = valid_r;
      req_nxt = req_r;
      sAddr_nxt = sAddr_r;
      if (sysWrite.finish)
      begin
         latch_nxt = sysWrite.addr; // RQ2
         valid_nxt = 1'b1; // RQ18
      end
      case (state_r)
         snpf_pkg::SNPF_IDLE:
            // Same-line writes skip the host entirely
            if (sysWrite.start && !sameLine) // RQ3
            begin
               req_nxt = 1'b1; // RQ4 RQ8
               sAddr_nxt = sysWrite.addr; // RQ1
               state_nxt = snpf_pkg::SNPF_REQ;
            end
         snpf_pkg::SNPF_REQ:
            if (!snoopAcknowledge_n)
            begin
               req_nxt = 1'b0; // RQ4
               state_nxt = snpf_pkg::SNPF_WAIT;
            end
         snpf_pkg::SNPF_WAIT:
            if (snoopAcknowledge_n)
               state_nxt = snpf_pkg::SNPF_IDLE;
         default:
         begin
            req_nxt = 1'b0;
            state_nxt = snpf_pkg::SNPF_IDLE;
         end
      endcase
      if (ownershipChange)
         valid_nxt = 1'b0; // RQ5 RQ18
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= snpf_pkg::SNPF_IDLE;
         latch_r <= `SNPF_ADDR_RST;
         valid_r <= 1'b0;
         req_r <= 1'b0;
         sAddr_r <= `SNPF_ADDR_RST;
      end
      else
      begin
         state_r <= state_nxt;
         latch_r <= latch_nxt;
         valid_r <= valid_nxt;
         req_r <= req_nxt;
         sAddr_r <= sAddr_nxt;
      end
   end

   // Ready stretch; bursts cannot wait, so they only lose one clock
   always_comb
   begin
      stall_nxt = stall_r;
      burstDip_nxt = 1'b0;
      if (sysWrite.start && sysWrite.processorSubsystem && pending && !sysWrite.burst)
         stall_nxt = 1'b1; // RQ6
      else if (stall_r && snoopAcknowledge_n && !req_r)
         stall_nxt = 1'b0; // RQ6
      if (sysWrite.start && sysWrite.burst && pending && !burstDip_r)
         burstDip_nxt = 1'b1; // RQ7
      rdy_nxt = !(stall_nxt || burstDip_nxt);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stall_r <= 1'b0;
         burstDip_r <= 1'b0;
         rdy_r <= 1'b1;
      end
      else
      begin
         stall_r <= stall_nxt;
         burstDip_r <= burstDip_nxt;
         rdy_r <= rdy_nxt;
      end
   end

   assign snoopRequest = req_r;
   assign snoopAddr = sAddr_r;
   assign memoryReady = rdy_r;

   property p_req_after_miss;
      @(posedge clk) disable iff (rst)
      (state_r == snpf_pkg::SNPF_IDLE && sysWrite.start && !sameLine) |=> snoopRequest;
   endproperty
   a_req_after_miss: assert property (p_req_after_miss) else $error("no request on miss"); // RQ8

   property p_hit_quiet;
      @(posedge clk) disable iff (rst)
      (state_r == snpf_pkg::SNPF_IDLE && sysWrite.start && sameLine) |=> !snoopRequest;
   endproperty
   a_hit_quiet: assert property (p_hit_quiet) else $error("request on line hit"); // RQ3

   property p_latch;
      @(posedge clk) disable iff (rst)
      sysWrite.finish |=> (latch_r == $past(sysWrite.addr));
   endproperty
   a_latch: assert property (p_latch) else $error("latch not loaded"); // RQ2

   property p_own_clear;
      @(posedge clk) disable iff (rst)
      ownershipChange |=> !valid_r;
   endproperty
   a_own_clear: assert property (p_own_clear) else $error("filter not cleared"); // RQ5

   property p_req_drop;
      @(posedge clk) disable iff (rst)
      (snoopRequest && !snoopAcknowledge_n) |=> !snoopRequest;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("request held after ack"); // RQ4

   sequence s_dip;
      !memoryReady ##1 memoryReady;
   endsequence
   property p_burst_one;
      @(posedge clk) disable iff (rst)
      (burstDip_r && !stall_r && !stall_nxt) |-> s_dip;
   endproperty
   a_burst_one: assert property (p_burst_one) else $error("burst dip not one clock"); // RQ7

   property p_stall;
      @(posedge clk) disable iff (rst)
      stall_r |-> !memoryReady;
   endproperty
   a_stall: assert property (p_stall) else $error("ready high while stalled"); // RQ6

   property p_addr;
      @(posedge clk) disable iff (rst)
      $rose(snoopRequest) |-> (snoopAddr == $past(sysWrite.addr));
   endproperty
   a_addr: assert property (p_addr) else $error("wrong snoop address"); // RQ1

   property p_stall_entry;
      @(posedge clk) disable iff (rst)
      (sysWrite.start && sysWrite.processorSubsystem && !sysWrite.burst && pending)
         |=> !memoryReady;
   endproperty
   a_stall_entry: assert property (p_stall_entry) else $error("write not stretched"); // RQ6

   property p_stall_release;
      @(posedge clk) disable iff (rst)
      ($rose(snoopAcknowledge_n) && !snoopRequest && !sysWrite.start) |=> memoryReady;
   endproperty
   a_stall_release: assert property (p_stall_release) else $error("ready not restored"); // RQ6

   property p_burst_dip;
      @(posedge clk) disable iff (rst)
      (sysWrite.start && sysWrite.burst && pending && !burstDip_r) |=> !memoryReady;
   endproperty
   a_burst_dip: assert property (p_burst_dip) else $error("burst not held one clock"); // RQ7

   property p_invalid_miss;
      @(posedge clk) disable iff (rst)
      (state_r == snpf_pkg::SNPF_IDLE && sysWrite.start && !valid_r) |=> snoopRequest;
   endproperty
   a_invalid_miss: assert property (p_invalid_miss) else $error("stale filter hit"); // RQ18
endmodule

/* pkg/snpf_map.svh */
`ifndef SNPF_MAP_SVH
`define SNPF_MAP_SVH
`define SNPF_ADDR_W 32
`define SNPF_LSZ_W 2
`define SNPF_LSZ_16 2'h0
`define SNPF_LSZ_32 2'h1
`define SNPF_LSZ_64 2'h2
`define SNPF_LSZ_128 2'h3
`define SNPF_LINE_LSB_16 4
`define SNPF_LINE_LSB_32 5
`define SNPF_LINE_LSB_64 6
`define SNPF_LINE_LSB_128 7
`define SNPF_ADDR_RST 32'h00000000
`endif

/* pkg/snpf_pkg.sv */
package snpf_pkg;
   typedef enum logic [1:0] {
      SNPF_IDLE = 2'h0,
      SNPF_REQ = 2'h1,
      SNPF_WAIT = 2'h3
   } snpf_state_t;
   typedef struct packed {
      logic start;
      logic finish;
      logic burst;
      logic processorSubsystem;
      logic [31:0] addr;
   } snpf_write_t;
endpackage

/* test/snpf_host_model.sv */
`timescale 1ns/10ps
module snpf_host_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Snoop handshake
   input wire logic snoopRequest,
   input wire logic [3:0] ackDelay,
   output logic snoopAcknowledge_n
);
   logic [3:0] waitCnt_r;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         waitCnt_r <= 4'h0;
         snoopAcknowledge_n <= 1'b1;
      end
      else if (snoopRequest && snoopAcknowledge_n)
      begin
         // Bounded wait, so a slow host is tested; misses arriving meanwhile get no snoop of their own
         if (waitCnt_r == ackDelay)
         begin
            snoopAcknowledge_n <= 1'b0;
            waitCnt_r <= 4'h0;
         end
         else
            waitCnt_r <= waitCnt_r + 4'h1;
      end
      else if (!snoopRequest)
         snoopAcknowledge_n <= 1'b1;
   end
endmodule

/* test/tb_snoop_filter_handshake.sv */
`timescale 1ns/10ps
module tb_snoop_filter_handshake;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic oc = 1'b0;
   logic [1:0] ls = 2'h0;
   logic [3:0] dly = 4'h3;
   snpf_pkg::snpf_write_t w = '0;
   logic ackN, req, memory_ready;
   logic [31:0] sa;
   int failures = 0;
   int comparisons = 0;
   always #10 clk = ~clk;
   snpf_filter dut (.clk(clk), .rst(rst), .sysWrite(w), .ownershipChange(oc), .lineSize(ls),
      .snoopAcknowledge_n(ackN), .snoopRequest(req), .snoopAddr(sa), .memoryReady(memory_ready));
   snpf_host_model host (.clk(clk), .rst(rst), .snoopRequest(req), .ackDelay(dly),
      .snoopAcknowledge_n(ackN));
   task close_out;
      if (failures == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task step;
      @(posedge clk);
      #1;
   endtask
   task waitIdle;
      int n;
      n = 0;
      while (!(req === 1'b0 && ackN === 1'b1))
      begin
         step;
         n++;
         if (n > 60)
         begin
            failures++;
            close_out;
         end
      end
      step;
   endtask
   // One write: start, judge the answer, then finish latches the address
   task wr(input logic [31:0] a, input logic b, p, er, input logic [31:0] ea, input logic em);
      w.addr = a;
      w.burst = b;
      w.processorSubsystem = p;
      w.start = 1'b1;
      step;
      w.start = 1'b0;
      chk(32'(req), 32'(er));
      if (er)
         chk(sa, ea);
      chk(32'(memory_ready), 32'(em));
      w.finish = 1'b1;
      step;
      w.finish = 1'b0;
   endtask
   task lineCase;
      logic [31:0] base, lb;
      for (int i = 0; i < 4; i++)
      begin
         ls = 2'(i);
         base = 32'h00010000 * (i + 1);
         lb = 32'h10 << i;
         wr(base, 1'b0, 1'b0, 1'b1, base, 1'b1);
         waitIdle;
         wr(base + lb - 32'h1, 1'b0, 1'b0, 1'b0, base, 1'b1);
         waitIdle;
         wr(base + lb, 1'b0, 1'b0, 1'b1, base + lb, 1'b1);
         waitIdle;
      end
   endtask
   task ownCase;
      wr(32'h0000A000, 1'b0, 1'b0, 1'b1, 32'h0000A000, 1'b1);
      waitIdle;
      oc = 1'b1;
      step;
      oc = 1'b0;
      wr(32'h0000A000, 1'b0, 1'b0, 1'b1, 32'h0000A000, 1'b1);
      waitIdle;
   endtask
   task readyCase;
      dly = 4'h6;
      wr(32'h2000, 1'b0, 1'b1, 1'b1, 32'h2000, 1'b1);
      wr(32'h3000, 1'b0, 1'b1, 1'b1, 32'h2000, 1'b0);
      chk(32'(memory_ready), 32'h0);
      waitIdle;
      chk(32'(memory_ready), 32'h1);
      wr(32'h4000, 1'b0, 1'b0, 1'b1, 32'h4000, 1'b1);
      wr(32'h5000, 1'b1, 1'b0, 1'b1, 32'h4000, 1'b0);
      chk(32'(memory_ready), 32'h1);
      waitIdle;
   endtask
   // Mid-run reset must empty the filter; other masters' non-burst writes never stretch
   task resetCase;
      wr(32'h00006000, 1'b0, 1'b0, 1'b1, 32'h00006000, 1'b1);
      waitIdle;
      rst = 1'b1;
      step;
      rst = 1'b0;
      chk(32'(req), 32'h0);
      chk(32'(memory_ready), 32'h1);
      wr(32'h00006000, 1'b0, 1'b0, 1'b1, 32'h00006000, 1'b1);
      wr(32'h00007000, 1'b0, 1'b0, 1'b1, 32'h00006000, 1'b1);
      waitIdle;
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      chk(32'(memory_ready), 32'h1);
      chk(32'(req), 32'h0);
      wr(32'h0, 1'b0, 1'b0, 1'b1, 32'h0, 1'b1);
      waitIdle;
      lineCase;
      ownCase;
      readyCase;
      resetCase;
      close_out;
   end
endmodule
